// ==== hw/shp_handler_ctrl.sv ====
// shp_handler_ctrl: priority word three and handler control and state,
// reached over classic Wishbone; assumes the core drives fault, entry and
// exit pulses on the same clock and flags privileged bus accesses.
`timescale 1ns/1ps

// Contract
// RQ1: both registers accept reads and writes only from privileged accesses.
// RQ2: the priority word is written per byte lane so neighbours stay intact.
// RQ3: the priority word sits at offset 0xD20 above base 0xE000E000.
// RQ4: each priority is a 3-bit writable level 0 to 7 that resets to 0.
// RQ5: timer priority is bits 31:29, deferred service 23:21, debug 7:5.
// RQ6: the control and state word sits at offset 0xD24.
// RQ7: the control word holds enables, fault and call pending, and active bits.
// RQ8: a fault whose enable is clear is escalated to a hard fault.
// RQ9: software writes to pending and active bits change the real state.
// RQ10: privileged software may rewrite active bits for a context switch.
// RQ11: changing active bits out of step with the stacked context raises a fault.
// RQ12: software saves the active bits before a write and restores them after.
// RQ13: after enabling, software changes bits only by read, modify and write.
// RQ14: among configurable priorities the lower value is the more urgent.
// RQ15: bit 18 enables the usage fault when set and resets to disabled.
// RQ16: reserved bits of the priority word read as zero and ignore writes.
module shp_handler_ctrl (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // register bus
  input  wire shp_pkg::shp_wb_req_t wb_req,
  input  wire logic                 wb_priv,
  output logic                      wb_ack,
  output logic [31:0]               wb_dat_o,
  // fault and call events from the core
  input  wire shp_pkg::shp_fault_t  fault_event,
  input  wire logic                 svc_call,
  input  wire shp_pkg::shp_fault_t  fault_taken,
  input  wire logic                 svc_taken,
  input  wire shp_pkg::shp_act_t    act_enter,
  input  wire shp_pkg::shp_act_t    act_exit,
  input  wire shp_pkg::shp_act_t    stacked_active,
  // state toward the core
  output shp_pkg::shp_fault_t       fault_pending,
  output logic                      svc_pending,
  output shp_pkg::shp_act_t         active,
  output logic                      hard_fault,
  output logic                      context_fault,
  // priority levels and urgent pick
  input  wire logic [2:0]           sys_request,
  output logic [2:0]                prio_timer,
  output logic [2:0]                prio_defer,
  output logic [2:0]                prio_debug,
  output logic                      pick_valid,
  output logic [1:0]                pick_id,
  output logic [2:0]                pick_level
);
  import shp_pkg::*;

  shp_bus_state_t state;
  shp_bus_state_t next_state;
  logic [31:0]    rdata;
  logic [31:0]    next_rdata;
  logic [2:0]     next_prio_timer;
  logic [2:0]     next_prio_defer;
  logic [2:0]     next_prio_debug;
  logic [2:0]     en;
  logic [2:0]     next_en;
  logic [2:0]     pend;
  logic [2:0]     next_pend;
  logic           next_svc_pending;
  logic [6:0]     act;
  logic [6:0]     next_act;
  logic           next_hard_fault;
  logic           next_context_fault;
  logic           hit_prio;
  logic           hit_ctrl;
  logic           req_new;
  logic           wr_prio;
  logic           wr_ctrl;
  logic [31:0]    prio_word;
  logic [31:0]    ctrl_word;
  logic [31:0]    ctrl_wr;
  logic [2:0]     evt;
  logic [6:0]     wr_act;

  // decode against the full bus address
  assign hit_prio = wb_req.adr == (SHP_SCS_BASE + {20'h00000, SHP_OFS_PRIO3}); // see RQ3
  assign hit_ctrl = wb_req.adr == (SHP_SCS_BASE + {20'h00000, SHP_OFS_CTRL});  // see RQ6
  assign req_new  = (state == SHP_BUS_IDLE) && wb_req.cyc && wb_req.stb;
  // writes land on the edge that closes the ack cycle
  assign wr_prio  = (state == SHP_BUS_ANSWER) && wb_req.we && wb_priv && hit_prio; // see RQ1
  assign wr_ctrl  = (state == SHP_BUS_ANSWER) && wb_req.we && wb_priv && hit_ctrl; // see RQ1
  assign wb_ack   = state == SHP_BUS_ANSWER;
  assign wb_dat_o = rdata;
  assign evt      = fault_event;

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction

  // priority word, reserved bits zero
  always_comb begin
    prio_word = 32'h00000000; // see RQ16
    prio_word[SHP_TIMER_LSB +: SHP_PRIO_W] = prio_timer; // see RQ5
    prio_word[SHP_DEFER_LSB +: SHP_PRIO_W] = prio_defer; // see RQ5
    prio_word[SHP_DEBUG_LSB +: SHP_PRIO_W] = prio_debug; // see RQ5
  end

  // control and state word
  always_comb begin
    ctrl_word = 32'h00000000;
    for (int f = 0; f < 3; f++) begin
      ctrl_word[SHP_EN_POS[f]]   = en[f];   // see RQ7
      ctrl_word[SHP_PEND_POS[f]] = pend[f]; // see RQ7
    end
    ctrl_word[SHP_PEND_SVC] = svc_pending;
    for (int a = 0; a < 7; a++) begin
      ctrl_word[SHP_ACT_POS[a]] = act[a];
    end
  end

  // bus state and read data
  always_comb begin
    next_state = state;
    next_rdata = rdata;
    unique case (state)
      SHP_BUS_IDLE: begin
        if (req_new) begin
          next_state = SHP_BUS_ANSWER;
          if (!wb_priv) begin
            next_rdata = SHP_READ_NONE; // see RQ1
          end else if (hit_prio) begin
            next_rdata = prio_word;
          end else if (hit_ctrl) begin
            next_rdata = ctrl_word;
          end else begin
            next_rdata = SHP_READ_NONE;
          end
        end
      end
      SHP_BUS_ANSWER: begin
        next_state = SHP_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= SHP_BUS_IDLE;
      rdata <= SHP_READ_NONE;
    end else begin
      state <= next_state;
      rdata <= next_rdata;
    end
  end

  // priorities, written lane by lane
  always_comb begin
    next_prio_timer = prio_timer;
    next_prio_defer = prio_defer;
    next_prio_debug = prio_debug;
    if (wr_prio) begin
      if (wb_req.sel[3]) begin
        next_prio_timer = wb_req.dat[SHP_TIMER_LSB +: SHP_PRIO_W]; // see RQ2
      end
      if (wb_req.sel[2]) begin
        next_prio_defer = wb_req.dat[SHP_DEFER_LSB +: SHP_PRIO_W]; // see RQ2
      end
      if (wb_req.sel[0]) begin
        next_prio_debug = wb_req.dat[SHP_DEBUG_LSB +: SHP_PRIO_W]; // see RQ2
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prio_timer <= SHP_PRIO_RST; // see RQ4
      prio_defer <= SHP_PRIO_RST; // see RQ4
      prio_debug <= SHP_PRIO_RST; // see RQ4
    end else begin
      prio_timer <= next_prio_timer;
      prio_defer <= next_prio_defer;
      prio_debug <= next_prio_debug;
    end
  end

  // enables, pending and active state; hardware set wins over any clear
  always_comb begin
    ctrl_wr = merge_lanes(ctrl_word, wb_req.dat, wb_req.sel);
    for (int a = 0; a < 7; a++) begin
      wr_act[a] = ctrl_wr[SHP_ACT_POS[a]];
    end
    next_en          = en;
    next_pend        = pend;
    next_svc_pending = svc_pending;
    next_act         = act;
    if (wr_ctrl) begin
      for (int f = 0; f < 3; f++) begin
        next_en[f]   = ctrl_wr[SHP_EN_POS[f]];   // see RQ15
        next_pend[f] = ctrl_wr[SHP_PEND_POS[f]]; // see RQ9
      end
      next_svc_pending = ctrl_wr[SHP_PEND_SVC];  // see RQ9
      next_act         = wr_act;                 // see RQ10
    end
    next_pend        = (next_pend & ~3'(fault_taken)) | (evt & en); // see RQ7
    next_svc_pending = (next_svc_pending & ~svc_taken) | svc_call;
    next_act         = (next_act & ~7'(act_exit)) | 7'(act_enter);
    next_hard_fault  = |(evt & ~en); // see RQ8
    next_context_fault = wr_ctrl && (wr_act != act)
                         && (wr_act != 7'(stacked_active)); // see RQ11
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en            <= SHP_CTRL_RST[2:0]; // see RQ15
      pend          <= SHP_CTRL_RST[2:0];
      svc_pending   <= 1'b0;
      act           <= SHP_CTRL_RST[6:0];
      hard_fault    <= 1'b0;
      context_fault <= 1'b0;
    end else begin
      en            <= next_en;
      pend          <= next_pend;
      svc_pending   <= next_svc_pending;
      act           <= next_act;
      hard_fault    <= next_hard_fault;
      context_fault <= next_context_fault;
    end
  end

  assign fault_pending = pend;
  assign active        = act;

  // most urgent of timer, deferred service and debug handlers
  shp_prio_pick #(
    .N (3),
    .W (SHP_PRIO_W)
  ) u_pick (
    .clock  (clock),
    .resetn (resetn),
    .req    (sys_request),
    .levels ({prio_debug, prio_defer, prio_timer}), // see RQ14
    .valid  (pick_valid),
    .id     (pick_id),
    .level  (pick_level)
  );

  chk_unpriv_write: assert property (@(posedge clock) disable iff (!resetn)
    wb_ack && wb_req.we && !wb_priv |=> $stable(prio_word) && $stable(en)) // see RQ1
    else $error("unprivileged write altered a register");

  chk_unpriv_read: assert property (@(posedge clock) disable iff (!resetn)
    req_new && !wb_priv |=> wb_ack && wb_dat_o == 32'h00000000) // see RQ1
    else $error("unprivileged read returned data");

  chk_byte_lane: assert property (@(posedge clock) disable iff (!resetn)
    wr_prio && !wb_req.sel[3] && !wb_req.sel[2]
    |=> $stable(prio_timer) && $stable(prio_defer)) // see RQ2
    else $error("unselected priority lane changed");

  chk_prio_read: assert property (@(posedge clock) disable iff (!resetn)
    req_new && wb_priv && hit_prio && !wb_req.we
    |=> wb_dat_o[31:29] == prio_timer && wb_dat_o[23:21] == prio_defer
        && wb_dat_o[7:5] == prio_debug) // see RQ5
    else $error("priority word read mismatch");

  chk_prio_reserved: assert property (@(posedge clock) disable iff (!resetn)
    req_new && hit_prio |=> (wb_dat_o & 32'h1F1FFF1F) == 32'h00000000) // see RQ16
    else $error("reserved priority bits read nonzero");

  chk_prio_write: assert property (@(posedge clock) disable iff (!resetn)
    wr_prio && wb_req.sel[3] |=> prio_timer == $past(wb_req.dat[31:29])) // see RQ4
    else $error("timer priority not written");

  chk_ctrl_read: assert property (@(posedge clock) disable iff (!resetn)
    req_new && wb_priv && hit_ctrl |=> wb_dat_o == $past(ctrl_word)) // see RQ6
    else $error("control word read mismatch");

  chk_fault_escalate: assert property (@(posedge clock) disable iff (!resetn)
    fault_event.usage && !en[2] |=> hard_fault && !($rose(pend[2]))) // see RQ8
    else $error("disabled usage fault not escalated");

  chk_fault_pend: assert property (@(posedge clock) disable iff (!resetn)
    fault_event.bus && en[1]
    |=> pend[1] && (hard_fault == ($past(fault_event.usage) && !$past(en[2])
        || $past(fault_event.mem) && !$past(en[0])))) // see RQ7
    else $error("enabled bus fault not pending");

  chk_usage_enable: assert property (@(posedge clock) disable iff (!resetn)
    wr_ctrl && wb_req.sel[2] |=> en[2] == $past(wb_req.dat[18])) // see RQ15
    else $error("usage enable not written");

  chk_active_write: assert property (@(posedge clock) disable iff (!resetn)
    wr_ctrl && wb_req.sel[1] && !act_enter.timer && !act_exit.timer
    |=> act[6] == $past(wb_req.dat[11])) // see RQ10
    else $error("timer active bit not written");

  chk_ctx_fault: assert property (@(posedge clock) disable iff (!resetn)
    context_fault |-> $past(wr_ctrl) && $past(wr_act) != $past(stacked_active)) // see RQ11
    else $error("context fault without mismatch");

  chk_pick_urgent: assert property (@(posedge clock) disable iff (!resetn)
    sys_request[0] && sys_request[1] && prio_timer < prio_defer
    |=> pick_valid && pick_id != 2'h1 && pick_level < $past(prio_defer)) // see RQ14
    else $error("less urgent handler picked");

endmodule

// ==== hw/shp_pkg.sv ====
// shp_pkg: constants, carriers and types of the system handler priority
// and control block; assumes a 32-bit classic Wishbone register path.
package shp_pkg;

  // address map
  localparam logic [31:0] SHP_SCS_BASE  = 32'hE000E000;
  localparam logic [11:0] SHP_OFS_PRIO3 = 12'hD20;
  localparam logic [11:0] SHP_OFS_CTRL  = 12'hD24;

  // priority word three fields
  localparam int          SHP_PRIO_W    = 3;
  localparam int          SHP_TIMER_LSB = 29;
  localparam int          SHP_DEFER_LSB = 21;
  localparam int          SHP_DEBUG_LSB = 5;
  localparam logic [2:0]  SHP_PRIO_RST  = 3'h0;

  // control and state fields, index 0 mem, 1 bus, 2 usage
  localparam int SHP_EN_POS   [0:2] = '{16, 17, 18};
  localparam int SHP_PEND_POS [0:2] = '{13, 14, 12};
  localparam int SHP_PEND_SVC       = 15;
  // active bits, index 0 mem .. 6 timer
  localparam int SHP_ACT_POS  [0:6] = '{0, 1, 3, 7, 8, 10, 11};
  localparam logic [31:0] SHP_CTRL_RST  = 32'h00000000;
  localparam logic [31:0] SHP_READ_NONE = 32'h00000000;

  // classic Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [31:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } shp_wb_req_t;

  // configurable faults
  typedef struct packed {
    logic usage;
    logic bus;
    logic mem;
  } shp_fault_t;

  // handlers with an active bit
  typedef struct packed {
    logic timer;
    logic defer;
    logic debug;
    logic supervisor_call;
    logic usage;
    logic bus;
    logic mem;
  } shp_act_t;

  typedef enum {SHP_BUS_IDLE, SHP_BUS_ANSWER} shp_bus_state_t;

endpackage

// ==== hw/shp_prio_pick.sv ====
// shp_prio_pick: registered pick of the most urgent requesting handler;
// assumes requests and levels come from logic on the same clock.
`timescale 1ns/1ps
module shp_prio_pick #(
  parameter int N = 3,
  parameter int W = 3
) (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 resetn,
  // candidates
  input  wire logic [N-1:0]         req,
  input  wire logic [N*W-1:0]       levels,
  // result
  output logic                      valid,
  output logic [$clog2(N+1)-1:0]    id,
  output logic [W-1:0]              level
);

  localparam int IW = $clog2(N + 1);

  generate
    if (N < 2 || W < 1) begin : g_bad
      $error("shp_prio_pick needs N >= 2 and W >= 1");
    end
  endgenerate

  logic [W-1:0]  lvl [N];
  logic          next_valid;
  logic [IW-1:0] next_id;
  logic [W-1:0]  next_level;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_lvl
      assign lvl[g] = levels[g*W +: W];
    end
  endgenerate

  // lower value is more urgent, ties go to the lower index
  always_comb begin
    next_valid = 1'b0;
    next_id    = '0;
    next_level = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i] && (!next_valid || lvl[i] < next_level)) begin
        next_valid = 1'b1;
        next_id    = IW'(i);
        next_level = lvl[i];
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      valid <= 1'b0;
      id    <= '0;
      level <= '0;
    end else begin
      valid <= next_valid;
      id    <= next_id;
      level <= next_level;
    end
  end

endmodule

// ==== test/shp_handler_ctrl_test.sv ====
// shp_handler_ctrl_test: self-checking bench for the handler priority and
// control block; drives Wishbone and core event ports directly.
`timescale 1ns/1ps
module shp_handler_ctrl_test;
  import shp_pkg::*;

  localparam logic [31:0] A_PRIO = SHP_SCS_BASE + {20'h0, SHP_OFS_PRIO3};
  localparam logic [31:0] A_CTRL = SHP_SCS_BASE + {20'h0, SHP_OFS_CTRL};
  localparam logic [31:0] A_NONE = SHP_SCS_BASE + 32'h00000D28;

  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  shp_wb_req_t wb_req = '0;
  logic        wb_priv = 1'b1;
  logic        wb_ack;
  logic [31:0] wb_dat_o;
  shp_fault_t  fault_event = '0;
  logic        svc_call = 1'b0;
  shp_fault_t  fault_taken = '0;
  logic        svc_taken = 1'b0;
  shp_act_t    act_enter = '0;
  shp_act_t    act_exit = '0;
  shp_act_t    stacked_active = '0;
  shp_fault_t  fault_pending;
  logic        svc_pending;
  shp_act_t    active;
  logic        hard_fault;
  logic        context_fault;
  logic [2:0]  sys_request = 3'h0;
  logic [2:0]  prio_timer;
  logic [2:0]  prio_defer;
  logic [2:0]  prio_debug;
  logic        pick_valid;
  logic [1:0]  pick_id;
  logic [2:0]  pick_level;
  int          fails = 0;
  int          n_compared = 0;

  always #2.5 clock = ~clock;

  shp_handler_ctrl dut_u (
    .clock(clock), .resetn(resetn), .wb_req(wb_req), .wb_priv(wb_priv),
    .wb_ack(wb_ack), .wb_dat_o(wb_dat_o), .fault_event(fault_event),
    .svc_call(svc_call), .fault_taken(fault_taken), .svc_taken(svc_taken),
    .act_enter(act_enter), .act_exit(act_exit), .stacked_active(stacked_active),
    .fault_pending(fault_pending), .svc_pending(svc_pending), .active(active),
    .hard_fault(hard_fault), .context_fault(context_fault),
    .sys_request(sys_request), .prio_timer(prio_timer), .prio_defer(prio_defer),
    .prio_debug(prio_debug), .pick_valid(pick_valid), .pick_id(pick_id),
    .pick_level(pick_level)
  );

  task automatic conclude;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    chk_word(name, {31'h0, exp}, {31'h0, got});
  endtask

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [31:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    rd = wb_dat_o;
    wb_req <= '0;
    #1;
    if (k >= 20) begin
      fails++;
      $display("wrong value bus ack expected 1 seen none");
      conclude();
    end
  endtask

  task automatic wr(input logic [31:0] adr, input logic [3:0] sel, input logic [31:0] dat);
    logic [31:0] d;
    bus(1'b1, adr, sel, dat, d);
  endtask

  task automatic rd(input string name, input logic [31:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, adr, 4'hF, 32'h00000000, d);
    chk_word(name, exp, d);
  endtask

  // core pulses for one cycle, then outputs are looked at
  task automatic pulse(input shp_fault_t fe, input shp_fault_t ft, input logic sc,
                       input logic st, input shp_act_t en, input shp_act_t ex);
    @(posedge clock);
    fault_event <= fe;
    fault_taken <= ft;
    svc_call    <= sc;
    svc_taken   <= st;
    act_enter   <= en;
    act_exit    <= ex;
    @(posedge clock);
    fault_event <= '0;
    fault_taken <= '0;
    svc_call    <= 1'b0;
    svc_taken   <= 1'b0;
    act_enter   <= '0;
    act_exit    <= '0;
    #1;
  endtask

  initial begin
    logic [31:0] lv;
    logic        seen;
    repeat (20) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd("prio reset", A_PRIO, 32'h00000000);
    rd("ctrl reset", A_CTRL, SHP_CTRL_RST);
    for (int i = 0; i < 8; i++) begin
      lv = {29'h0, 3'(i)};
      wr(A_PRIO, 4'hF, {lv[2:0], 5'h1F, lv[2:0], 5'h1F, 8'hFF, lv[2:0], 5'h1F});
      rd("prio level", A_PRIO, {lv[2:0], 5'h0, lv[2:0], 13'h0, lv[2:0], 5'h0});
      chk_word("prio_debug", lv, {29'h0, prio_debug});
    end
    wr(A_PRIO, 4'h4, 32'h00000000);
    rd("prio lane 2", A_PRIO, 32'hE00000E0);
    wr(A_PRIO, 4'h1, 32'h00000000);
    rd("prio lane 0", A_PRIO, 32'hE0000000);
    rd("unmapped read", A_NONE, SHP_READ_NONE);
    @(posedge clock);
    wb_priv <= 1'b0;
    wr(A_PRIO, 4'hF, 32'hFFFFFFFF);
    rd("unpriv read", A_PRIO, 32'h00000000);
    wr(A_CTRL, 4'hF, 32'h00040000);
    @(posedge clock);
    wb_priv <= 1'b1;
    rd("prio after unpriv", A_PRIO, 32'hE0000000);
    rd("ctrl after unpriv", A_CTRL, 32'h00000000);
    wr(A_PRIO, 4'hF, 32'hA0400040);
    @(posedge clock);
    sys_request <= 3'b111;
    repeat (2) @(posedge clock);
    #1;
    chk_bit("pick_valid", 1'b1, pick_valid);
    chk_word("pick_id tie", 32'h1, {30'h0, pick_id});
    chk_word("pick_level", 32'h2, {29'h0, pick_level});
    @(posedge clock);
    sys_request <= 3'b001;
    repeat (2) @(posedge clock);
    #1;
    chk_word("pick_id timer", 32'h0, {30'h0, pick_id});
    chk_word("prio_timer", 32'h5, {29'h0, prio_timer});
    chk_word("prio_defer", 32'h2, {29'h0, prio_defer});
    wr(A_PRIO, 4'h8, 32'h20000000);
    @(posedge clock);
    sys_request <= 3'b011;
    repeat (2) @(posedge clock);
    #1;
    chk_word("pick_id urgent", 32'h0, {30'h0, pick_id});
    chk_word("pick_level urgent", 32'h1, {29'h0, pick_level});
    pulse(3'b100, '0, 1'b0, 1'b0, '0, '0);
    chk_bit("hard_fault usage off", 1'b1, hard_fault);
    chk_bit("usage off pending", 1'b0, fault_pending.usage);
    wr(A_CTRL, 4'hF, 32'h00040000);
    pulse(3'b100, '0, 1'b0, 1'b0, '0, '0);
    chk_bit("usage pending", 1'b1, fault_pending.usage);
    chk_bit("hard_fault enabled", 1'b0, hard_fault);
    pulse(3'b010, '0, 1'b0, 1'b0, '0, '0);
    chk_bit("hard_fault", 1'b1, hard_fault);
    chk_bit("bus pending", 1'b0, fault_pending.bus);
    @(posedge clock);
    #1;
    chk_bit("hard_fault drop", 1'b0, hard_fault);
    rd("ctrl pending", A_CTRL, 32'h00041000);
    wr(A_CTRL, 4'hF, 32'h0004A000);
    chk_word("pending sw", 32'h1, {29'h0, fault_pending});
    chk_bit("svc_pending sw", 1'b1, svc_pending);
    wr(A_CTRL, 4'hF, 32'h0004A800);
    seen = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (context_fault === 1'b1) seen = 1'b1;
      @(posedge clock);
      #1;
    end
    chk_bit("context_fault", 1'b1, seen);
    chk_bit("timer active sw", 1'b1, active.timer);
    // saved and restored active set matches the stacked context
    @(posedge clock);
    stacked_active <= 7'b1100000;
    wr(A_CTRL, 4'hF, 32'h0004AC00);
    seen = 1'b0;
    for (int k = 0; k < 3; k++) begin
      if (context_fault === 1'b1) seen = 1'b1;
      @(posedge clock);
      #1;
    end
    chk_bit("context_fault match", 1'b0, seen);
    chk_word("active sw", 32'h60, {25'h0, active});
    pulse('0, '0, 1'b0, 1'b0, 7'b0010000, 7'b1000000);
    rd("ctrl active", A_CTRL, 32'h0004A500);
    pulse('0, 3'b001, 1'b0, 1'b1, '0, '0);
    chk_word("pending taken", 32'h0, {29'h0, fault_pending});
    chk_bit("svc taken", 1'b0, svc_pending);
    pulse('0, '0, 1'b1, 1'b0, '0, '0);
    chk_bit("svc call", 1'b1, svc_pending);
    // enable bus fault, keeping the current active set
    wr(A_CTRL, 4'hF, 32'h00068500);
    pulse(3'b011, 3'b010, 1'b0, 1'b0, '0, '0);
    chk_bit("bus pending set wins", 1'b1, fault_pending.bus);
    chk_bit("hard_fault mem off", 1'b1, hard_fault);
    rd("ctrl bus pending", A_CTRL, 32'h0006C500);
    conclude();
  end
endmodule
